// >>> hw/btss_decode.sv
// btss_decode: combinational field split and class match of one opcode word
`timescale 1ns/1ns
`default_nettype none

module btss_decode (
   // opcode under decode
   input  wire logic [btss_pkg::OPC_W-1:0]  opcode_i,
   // decoded fields
   output logic                             is_btss_o,
   output logic [btss_pkg::BIT_W-1:0]       bit_idx_o,
   output logic [btss_pkg::ADDR_W-1:0]      reg_addr_o
);

   // class match and operand split
   always_comb begin
      is_btss_o  = (opcode_i[btss_pkg::CLASS_LSB +: btss_pkg::CLASS_W] == btss_pkg::CLASS_BTSS);
      bit_idx_o  = opcode_i[btss_pkg::BIT_LSB +: btss_pkg::BIT_W];
      reg_addr_o = opcode_i[btss_pkg::ADDR_LSB +: btss_pkg::ADDR_W];
   end

endmodule

`default_nettype wire

// >>> hw/btss_exec.sv
// btss_exec: prefetch register and execute stage of the bit-test-skip-if-set instruction
`timescale 1ns/1ns
`default_nettype none

module btss_exec (
   // clock and reset
   input  wire logic                             mclk_i,
   input  wire logic                             resetn_i,
   // prefetch side: word from program memory for the next cycle
   input  wire logic [btss_pkg::OPC_W-1:0]       instr_i,
   input  wire logic                             instr_valid_i,
   // register file side
   output logic      [btss_pkg::ADDR_W-1:0]      reg_addr_o,
   input  wire logic [btss_pkg::DATA_W-1:0]      reg_data_i,
   // execute stage towards the rest of the core
   output logic      [btss_pkg::OPC_W-1:0]       exec_instr_o,
   output logic                                  exec_valid_o,
   output logic                                  btss_active_o,
   output logic                                  skip_o
);

   // execute stage state
   logic [btss_pkg::OPC_W-1:0]  instr_q;
   logic [btss_pkg::OPC_W-1:0]  instr_d;
   logic                        valid_q;
   logic                        valid_d;
   logic                        btss_q;
   logic                        btss_d;
   logic [btss_pkg::BIT_W-1:0]  bit_idx_q;
   logic [btss_pkg::BIT_W-1:0]  bit_idx_d;
   logic [btss_pkg::ADDR_W-1:0] addr_q;
   logic [btss_pkg::ADDR_W-1:0] addr_d;
   logic                        skip_q;
   logic                        skip_d;

   // decode of the incoming prefetched word
   logic                        dec_btss;
   logic [btss_pkg::BIT_W-1:0]  dec_bit;
   logic [btss_pkg::ADDR_W-1:0] dec_addr;

   // result of the bit test in the present cycle
   logic                        bit_set;

   btss_decode u_decode (
      .opcode_i   (instr_i),
      .is_btss_o  (dec_btss),
      .bit_idx_o  (dec_bit),
      .reg_addr_o (dec_addr)
   );

   // bit test and next-stage selection
   always_comb begin
      bit_set = reg_data_i[bit_idx_q];
      skip_d  = valid_q & btss_q & bit_set;
      if (skip_d) begin
         // squash the prefetched word into a no-op
         instr_d   = btss_pkg::OPC_NOP;
         valid_d   = 1'h0;
         btss_d    = 1'h0;
         bit_idx_d = btss_pkg::RST_BIT;
         addr_d    = btss_pkg::RST_ADDR;
      end else if (instr_valid_i) begin
         // prefetched word moves into execute
         instr_d   = instr_i;
         valid_d   = 1'h1;
         btss_d    = dec_btss;
         bit_idx_d = dec_bit;
         addr_d    = dec_addr;
      end else begin
         // fetch bubble executes as a no-op
         instr_d   = btss_pkg::OPC_NOP;
         valid_d   = 1'h0;
         btss_d    = 1'h0;
         bit_idx_d = btss_pkg::RST_BIT;
         addr_d    = btss_pkg::RST_ADDR;
      end
   end

   // execute stage registers
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         instr_q   <= btss_pkg::RST_INSTR;
         valid_q   <= 1'h0;
         btss_q    <= 1'h0;
         bit_idx_q <= btss_pkg::RST_BIT;
         addr_q    <= btss_pkg::RST_ADDR;
         skip_q    <= 1'h0;
      end else begin
         instr_q   <= instr_d;
         valid_q   <= valid_d;
         btss_q    <= btss_d;
         bit_idx_q <= bit_idx_d;
         addr_q    <= addr_d;
         skip_q    <= skip_d;
      end
   end

   // outputs straight from the stage registers
   assign exec_instr_o  = instr_q;
   assign exec_valid_o  = valid_q;
   assign btss_active_o = btss_q;
   assign reg_addr_o    = addr_q;                 // register read during own execute cycle
   assign skip_o        = skip_q;                 // marks the squashed second cycle

   // a valid word of the skip class is flagged as such
   property p_decode;
      @(posedge mclk_i) disable iff (!resetn_i)
      exec_valid_o && (exec_instr_o[btss_pkg::CLASS_LSB +: btss_pkg::CLASS_W] == btss_pkg::CLASS_BTSS)
      |-> btss_active_o;
   endproperty
   a_decode: assert property (p_decode)
      else $error("skip-class opcode not flagged");

   // register address and bit come from the executing word
   property p_operands;
      @(posedge mclk_i) disable iff (!resetn_i)
      btss_active_o |-> (reg_addr_o == exec_instr_o[btss_pkg::ADDR_LSB +: btss_pkg::ADDR_W])
                        && (bit_idx_q == exec_instr_o[btss_pkg::BIT_LSB +: btss_pkg::BIT_W]);
   endproperty
   a_operands: assert property (p_operands)
      else $error("operand fields do not match executing word");

   // set bit leads to a skip in the next cycle
   property p_skip_taken;
      @(posedge mclk_i) disable iff (!resetn_i)
      btss_active_o && reg_data_i[exec_instr_o[btss_pkg::BIT_LSB +: btss_pkg::BIT_W]] |=> skip_o;
   endproperty
   a_skip_taken: assert property (p_skip_taken)
      else $error("set bit did not cause a skip");

   // clear bit never skips
   property p_no_skip;
      @(posedge mclk_i) disable iff (!resetn_i)
      btss_active_o && !reg_data_i[exec_instr_o[btss_pkg::BIT_LSB +: btss_pkg::BIT_W]] |=> !skip_o;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("clear bit caused a skip");

   // prefetched word executes in the following cycle
   property p_prefetch;
      @(posedge mclk_i) disable iff (!resetn_i)
      !skip_d && instr_valid_i |=> exec_valid_o && (exec_instr_o == $past(instr_i));
   endproperty
   a_prefetch: assert property (p_prefetch)
      else $error("prefetched word not executed next cycle");

   // a fetch bubble never executes
   property p_bubble;
      @(posedge mclk_i) disable iff (!resetn_i)
      !instr_valid_i |=> !exec_valid_o;
   endproperty
   a_bubble: assert property (p_bubble)
      else $error("bubble marked valid");

   // squashed cycle is an inert no-op
   property p_squash;
      @(posedge mclk_i) disable iff (!resetn_i)
      skip_o |-> !exec_valid_o && (exec_instr_o == btss_pkg::OPC_NOP) && !btss_active_o;
   endproperty
   a_squash: assert property (p_squash)
      else $error("squashed word not a no-op");

   // taken skip costs exactly one extra cycle
   property p_two_cycle;
      @(posedge mclk_i) disable iff (!resetn_i)
      $rose(skip_o) |-> $past(btss_active_o) ##1 !skip_o;
   endproperty
   a_two_cycle: assert property (p_two_cycle)
      else $error("skip not exactly two cycles");

   // reset leaves an inert no-op in execute
   property p_reset_idle;
      @(posedge mclk_i)
      !resetn_i |=> !exec_valid_o && !skip_o && !btss_active_o
                    && (exec_instr_o == btss_pkg::RST_INSTR) && (reg_addr_o == btss_pkg::RST_ADDR);
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("execute stage not idle after reset");

   // a cycle without a valid word is the no-op word and addresses register RST_ADDR
   property p_idle_nop;
      @(posedge mclk_i) disable iff (!resetn_i)
      !exec_valid_o |-> (exec_instr_o == btss_pkg::OPC_NOP) && !btss_active_o
                        && (reg_addr_o == btss_pkg::RST_ADDR);
   endproperty
   a_idle_nop: assert property (p_idle_nop)
      else $error("idle cycle not an inert no-op");

   // every valid word addresses the register named in its low bits
   property p_read_addr;
      @(posedge mclk_i) disable iff (!resetn_i)
      exec_valid_o |-> (reg_addr_o == exec_instr_o[btss_pkg::ADDR_LSB +: btss_pkg::ADDR_W]);
   endproperty
   a_read_addr: assert property (p_read_addr)
      else $error("register address differs from executing word");

   // a skip only ever follows a valid test word
   property p_skip_source;
      @(posedge mclk_i) disable iff (!resetn_i)
      skip_o |-> $past(btss_active_o) && $past(exec_valid_o);
   endproperty
   a_skip_source: assert property (p_skip_source)
      else $error("skip without a preceding test word");

   // squashed slots are never tested, so skips never chain
   property p_no_chain;
      @(posedge mclk_i) disable iff (!resetn_i)
      skip_o |=> !skip_o;
   endproperty
   a_no_chain: assert property (p_no_chain)
      else $error("skip lasted more than one cycle");

   // any other valid word completes in one cycle
   property p_other_one_cycle;
      @(posedge mclk_i) disable iff (!resetn_i)
      exec_valid_o && !btss_active_o |=> !skip_o;
   endproperty
   a_other_one_cycle: assert property (p_other_one_cycle)
      else $error("non-test word caused a skip");

endmodule

`default_nettype wire

// >>> hw/btss_pkg.sv
// btss_pkg: opcode layout, reset values and constants of the bit-test-skip-if-set executor
package btss_pkg;

   // opcode word geometry
   localparam int unsigned OPC_W      = 14;
   localparam int unsigned ADDR_W     = 7;
   localparam int unsigned BIT_W      = 3;
   localparam int unsigned DATA_W     = 8;

   // field positions inside the opcode word
   localparam int unsigned ADDR_LSB   = 0;
   localparam int unsigned BIT_LSB    = 7;
   localparam int unsigned CLASS_LSB  = 10;
   localparam int unsigned CLASS_W    = 4;

   // top bits 01 followed by 11 mark bit_test_skip_if_set
   localparam logic [CLASS_W-1:0] CLASS_BTSS = 4'h7;

   // no-operation word put in place of a squashed instruction
   localparam logic [OPC_W-1:0]  OPC_NOP    = 14'h0000;

   // values after reset
   localparam logic [OPC_W-1:0]  RST_INSTR  = 14'h0000;
   localparam logic [ADDR_W-1:0] RST_ADDR   = 7'h00;
   localparam logic [BIT_W-1:0]  RST_BIT    = 3'h0;

   // instruction cycles when the tested bit is zero, and when the skip is taken
   localparam int unsigned CYC_NOSKIP = 1;
   localparam int unsigned CYC_SKIP   = 2;

endpackage

// >>> verif/btss_regfile_model.sv
// btss_regfile_model: data register file behind the executor, loaded by the bench
`timescale 1ns/1ns
`default_nettype none

module btss_regfile_model (
   // clock and bench load port
   input  wire logic                        mclk_i,
   input  wire logic                        wr_en_i,
   input  wire logic [btss_pkg::ADDR_W-1:0] wr_addr_i,
   input  wire logic [btss_pkg::DATA_W-1:0] wr_data_i,
   // read port towards the executor
   input  wire logic [btss_pkg::ADDR_W-1:0] rd_addr_i,
   output logic      [btss_pkg::DATA_W-1:0] rd_data_o
);
   logic [btss_pkg::DATA_W-1:0] mem_q [128];

   // load on the rising edge
   always_ff @(posedge mclk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // same-cycle read of the addressed register
   assign rd_data_o = mem_q[rd_addr_i];
endmodule

`default_nettype wire

// >>> verif/tb.sv
// tb: directed and random instruction stream through the executor, checked at the end of every step and reset pulse
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic        mclk_i = 1'h0;
   logic        resetn_i = 1'h0;
   logic [13:0] instr_i = 14'h0000;
   logic        instr_valid_i = 1'h0;
   logic [6:0]  reg_addr_o;
   logic [7:0]  reg_data_i;
   logic [13:0] exec_instr_o;
   logic        exec_valid_o;
   logic        btss_active_o;
   logic        skip_o;
   logic        wr_en = 1'h0;
   logic [6:0]  wr_addr = 7'h00;
   logic [7:0]  wr_data = 8'h00;
   logic [7:0]  mem [128];
   logic [13:0] e_instr = 14'h0000;
   logic        e_valid = 1'h0;
   logic        e_act = 1'h0;
   int          err_total = 0;
   int          num_checks = 0;

   // clock, 8 ns period
   initial begin
      forever #4 mclk_i = ~mclk_i;
   end

   btss_exec i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .reg_addr_o(reg_addr_o), .reg_data_i(reg_data_i), .exec_instr_o(exec_instr_o),
      .exec_valid_o(exec_valid_o), .btss_active_o(btss_active_o), .skip_o(skip_o));
   btss_regfile_model i_regs (.mclk_i(mclk_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
      .rd_addr_i(reg_addr_o), .rd_data_o(reg_data_i));

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (exp !== got) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // skip taken when a valid test word finds its bit set
   function automatic logic taken(input logic [13:0] w, input logic act);
      return act && mem[w[6:0]][w[9:7]];
   endfunction

   // present one word at the falling edge, check the execute stage at the next falling edge
   task automatic step(input logic [13:0] w, input logic v);
      logic tk;
      tk = taken(e_instr, e_act);
      instr_i = w;
      instr_valid_i = v;
      @(negedge mclk_i);
      e_valid = v && !tk;
      e_instr = e_valid ? w : 14'h0000;
      e_act = e_valid && (w[13:10] == 4'h7);
      cmp("exec_instr_o", 16'(e_instr), 16'(exec_instr_o));
      cmp("exec_valid_o", 16'(e_valid), 16'(exec_valid_o));
      cmp("btss_active_o", 16'(e_act), 16'(btss_active_o));
      cmp("skip_o", 16'(tk), 16'(skip_o));
      cmp("reg_addr_o", 16'(e_instr[6:0]), 16'(reg_addr_o));
   endtask

   // load one register through a bubble cycle
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      wr_en = 1'h1;
      wr_addr = a;
      wr_data = d;
      mem[a] = d;
      step(14'h0000, 1'h0);
   endtask

   // synchronous reset in mid-run: execute stage returns to the idle no-op
   task automatic rst_pulse();
      resetn_i = 1'h0;
      instr_i = 14'h1FFF;
      instr_valid_i = 1'h1;
      repeat (2) @(negedge mclk_i);
      e_instr = btss_pkg::RST_INSTR;
      e_valid = 1'h0;
      e_act = 1'h0;
      cmp("exec_instr_o", 16'(e_instr), 16'(exec_instr_o));
      cmp("exec_valid_o", 16'(e_valid), 16'(exec_valid_o));
      cmp("btss_active_o", 16'(e_act), 16'(btss_active_o));
      cmp("skip_o", 16'h0000, 16'(skip_o));
      cmp("reg_addr_o", 16'(btss_pkg::RST_ADDR), 16'(reg_addr_o));
      resetn_i = 1'h1;
   endtask

   // main sequence
   initial begin
      logic [13:0] w;
      void'($urandom(34957));
      repeat (20) @(negedge mclk_i);
      resetn_i = 1'h1;
      for (int i = 0; i < 126; i++) begin
         wr(7'(i + 1), 8'($urandom));
      end
      wr(7'h7F, 8'h80);
      wr(7'h00, 8'hFE);
      wr_en = 1'h0;
      // every class with bit 7 of register 127 set; only 01 11 skips
      for (int c = 0; c < 16; c++) begin
         step({4'(c), 3'h7, 7'h7F}, 1'h1);
         step(14'h0155, 1'h1);
      end
      // back-to-back taken tests, the second one squashed, then a bubble
      step(14'h1FFF, 1'h1);
      step(14'h1FFF, 1'h1);
      step(14'h1FFF, 1'h1);
      step(14'h2AAA, 1'h0);
      // bit zero clear: next word executes at once
      step(14'h1C00, 1'h1);
      step(14'h0ABC, 1'h1);
      // reset with a taken skip pending drops the skip
      step(14'h1FFF, 1'h1);
      rst_pulse();
      step(14'h0ABC, 1'h1);
      for (int n = 0; n < 2000; n++) begin
         w = 14'($urandom);
         if ($urandom % 2 == 0) begin
            w[13:10] = 4'h7;
         end
         step(w, 1'(($urandom % 8) != 0));
      end
      give_verdict();
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge mclk_i);
      err_total++;
      give_verdict();
   end
endmodule

`default_nettype wire
